// ---- design/sdmr_pkg.sv ----
package sdmr_pkg;
	localparam int MR_W = 22;
	localparam int RSV_HI = 21;
	localparam int SEL_HI = 20;
	localparam int SEL_LO = 18;
	localparam int RSV_LO = 17;
	localparam int B_EQ2 = 13;
	localparam int B_QOFF = 12;
	localparam int B_EXTRA_TERM_STROBE = 11;
	localparam int NOM_HI = 10;
	localparam int NOM_LO = 8;
	localparam int B_WLVL = 7;
	localparam int B_EQ1 = 6;
	localparam int B_EQ0 = 5;
	localparam int AL_HI = 4;
	localparam int AL_LO = 3;
	localparam int DRV_HI = 2;
	localparam int DRV_LO = 1;
	localparam int B_DLL = 0;
	localparam int WT_HI = 11;
	localparam int WT_LO = 9;
	localparam int B_LOOP_RST = 8;
	localparam logic [2:0] SEL_MR0 = 3'h0;
	localparam logic [2:0] SEL_MR1 = 3'h1;
	localparam logic [2:0] SEL_MR2 = 3'h2;
	localparam logic [1:0] AL_CL1 = 2'h1;
	localparam logic [1:0] AL_CL2 = 2'h2;
	localparam logic [2:0] TERM_NONE = 3'h0;
	localparam logic [21:0] MR1_RESET = 22'h040001;
	localparam int LOCK_CYCLES_DEF = 1024;
	localparam logic [2:0] WR_TERM_WIN = 3'h4;
	localparam int AL_PIPE = 32;
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFF_WORD = 4'h0;
	localparam logic [3:0] OFF_CMD = 4'h4;
	localparam logic [3:0] OFF_CTRL = 4'h8;
	localparam logic [3:0] OFF_STAT = 4'hc;
	localparam int CTRL_ODT = 0;
	localparam int CTRL_GEAR = 1;
	localparam int ST_LOCKWAIT = 0;
	localparam int ST_DLL = 1;
	localparam int ST_SREF = 2;
	localparam int ST_REFUSED = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		CMD_NONE, CMD_MRS, CMD_ACT, CMD_RD, CMD_WR, CMD_REF, CMD_SRE, CMD_SRX
	} sdmr_cmd_t;

	typedef enum logic [1:0] {TERM_OFF, TERM_PARK, TERM_NOM, TERM_WR} sdmr_term_t;

	// Row strobe, column strobe, write enable levels, all active low.
	function automatic logic [2:0] sdmr_encode(input sdmr_cmd_t c);
		unique case (c)
			CMD_MRS: sdmr_encode = 3'h0;
			CMD_ACT: sdmr_encode = 3'h3;
			CMD_RD: sdmr_encode = 3'h5;
			CMD_WR: sdmr_encode = 3'h4;
			CMD_REF, CMD_SRE: sdmr_encode = 3'h1;
			default: sdmr_encode = 3'h7;
		endcase
	endfunction : sdmr_encode

	function automatic sdmr_cmd_t sdmr_decode(input logic csN,
		input logic [2:0] rcw);
		if (csN) begin
			sdmr_decode = CMD_NONE;
		end else begin
			unique case (rcw)
				3'h0: sdmr_decode = CMD_MRS;
				3'h3: sdmr_decode = CMD_ACT;
				3'h5: sdmr_decode = CMD_RD;
				3'h4: sdmr_decode = CMD_WR;
				3'h1: sdmr_decode = CMD_REF;
				default: sdmr_decode = CMD_NONE;
			endcase
		end
	endfunction : sdmr_decode
endpackage : sdmr_pkg

// ---- design/sdmr_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface sdmr_link_if;
	logic csN;
	logic rasN;
	logic casN;
	logic weN;
	logic [3:0] bank;
	logic [17:0] addr;
	logic cke;
	logic termination_control;
	modport ctrl (output csN, rasN, casN, weN, bank, addr, cke, termination_control);
	modport dram (input csN, rasN, casN, weN, bank, addr, cke, termination_control);
endinterface : sdmr_link_if
`default_nettype wire

// ---- design/sdmr_lock_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdmr_lock_timer #(
	parameter int CYCLES = sdmr_pkg::LOCK_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic restart,
	input wire logic run,
	output logic done
);
	import sdmr_pkg::*;
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] count;

	always_ff @(posedge clk) begin
		if (rst || restart) begin
			count <= '0;
		end else if (run && !done) begin
			count <= count + 1'b1;
		end
	end

	assign done = (count == CW'(CYCLES));
endmodule : sdmr_lock_timer
`default_nettype wire

// ---- design/sdmr_ctrl_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdmr_ctrl_end #(
	parameter int LOCK_CYCLES = sdmr_pkg::LOCK_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic rst,
	sdmr_link_if.ctrl link,
	input wire logic [sdmr_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [sdmr_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	import sdmr_pkg::*;

	logic awHeld;
	logic wHeld;
	logic [ADDR_W-1:0] wAddr;
	logic [31:0] wBuf;
	logic [3:0] sBuf;
	logic fire;
	logic [21:0] word;
	logic [1:0] ctrlReg;
	sdmr_cmd_t lastCmd;
	sdmr_cmd_t kind;
	logic dllOn;
	logic inSref;
	logic refused;
	logic refuse;
	logic locked;
	logic lockWait;
	logic restart;
	logic [21:0] sendWord;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : merge

	assign awready = !awHeld;
	assign wready = !wHeld;
	assign arready = !rvalid;
	assign fire = awHeld && wHeld && !bvalid;
	assign kind = sdmr_cmd_t'(wBuf[2:0]);
	assign lockWait = dllOn && !locked;

	// Reserved bits go out as zero, and without the loop no nominal or write termination.
	always_comb begin
		sendWord = word;
		sendWord[RSV_HI] = 1'b0; // [RULE3]
		sendWord[RSV_LO] = 1'b0; // [RULE3]
		if (word[SEL_HI:SEL_LO] == SEL_MR1 && !word[B_DLL]) begin
			sendWord[NOM_HI:NOM_LO] = TERM_NONE; // [RULE17]
		end
		if (word[SEL_HI:SEL_LO] == SEL_MR2 && !dllOn) begin
			sendWord[WT_HI:WT_LO] = TERM_NONE; // [RULE18]
		end
	end

	always_comb begin
		refuse = 1'b0;
		if (fire && wAddr == OFF_CMD) begin
			unique case (kind)
				CMD_MRS: refuse = word[SEL_HI:SEL_LO] == SEL_MR1 &&
					ctrlReg[CTRL_GEAR] &&
					word[AL_HI:AL_LO] == AL_CL1; // [RULE9]
				CMD_RD: refuse = lockWait || inSref; // [RULE14]
				CMD_SRE: refuse = lockWait || inSref; // [RULE15]
				CMD_SRX: refuse = !inSref;
				CMD_ACT, CMD_WR: refuse = inSref;
				default: refuse = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			wAddr <= '0;
			wBuf <= '0;
			sBuf <= '0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awHeld <= 1'b1;
				wAddr <= awaddr;
			end
			if (wvalid && wready) begin
				wHeld <= 1'b1;
				wBuf <= wdata;
				sBuf <= wstrb;
			end
			if (fire) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (wAddr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			word <= '0;
			ctrlReg <= '0;
		end else if (fire && wAddr == OFF_WORD) begin
			word <= 22'(merge({10'h000, word}, wBuf, sBuf));
		end else if (fire && wAddr == OFF_CTRL) begin
			ctrlReg <= 2'(merge({30'h0, ctrlReg}, wBuf, sBuf));
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			refused <= 1'b0;
		end else if (refuse) begin
			refused <= 1'b1;
		end else if (fire && wAddr == OFF_STAT && sBuf[0] &&
			wBuf[ST_REFUSED]) begin
			refused <= 1'b0;
		end
	end

	// Chip select and strobes return to idle after every one-cycle command.
	always_ff @(posedge clk) begin
		if (rst) begin
			link.csN <= 1'b1;
			{link.rasN, link.casN, link.weN} <= 3'h7;
			link.bank <= '0;
			link.addr <= '0;
			link.cke <= 1'b1;
			link.termination_control <= 1'b0;
			lastCmd <= CMD_NONE;
			dllOn <= 1'b1;
			inSref <= 1'b0;
			restart <= 1'b0;
		end else begin
			link.csN <= 1'b1;
			{link.rasN, link.casN, link.weN} <= 3'h7;
			link.termination_control <= ctrlReg[CTRL_ODT] && dllOn && !inSref; // [RULE17]
			restart <= 1'b0;
			if (fire && wAddr == OFF_CMD && !refuse) begin
				lastCmd <= kind;
				if (kind != CMD_SRX) begin
					link.csN <= 1'b0;
					{link.rasN, link.casN, link.weN} <= sdmr_encode(kind); // [RULE2]
				end
				if (kind == CMD_MRS) begin
					{link.bank, link.addr} <= sendWord; // [RULE1]
				end
				if (kind == CMD_MRS && word[SEL_HI:SEL_LO] == SEL_MR1) begin
					dllOn <= word[B_DLL];
					restart <= word[B_DLL] && !dllOn; // [RULE12]
				end
				if (kind == CMD_MRS && word[SEL_HI:SEL_LO] == SEL_MR0) begin
					restart <= word[B_LOOP_RST]; // [RULE14]
				end
				if (kind == CMD_SRE) begin
					link.cke <= 1'b0;
					inSref <= 1'b1;
				end
				if (kind == CMD_SRX) begin
					link.cke <= 1'b1;
					inSref <= 1'b0;
					restart <= dllOn; // [RULE14]
				end
			end
		end
	end

	sdmr_lock_timer #(.CYCLES(LOCK_CYCLES)) lockTimer (
		.clk(clk),
		.rst(rst),
		.restart(restart),
		.run(dllOn && !inSref),
		.done(locked)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= RESP_OKAY;
			unique case (araddr)
				OFF_WORD: rdata <= {10'h000, word};
				OFF_CMD: rdata <= {29'h0, lastCmd};
				OFF_CTRL: rdata <= {30'h0, ctrlReg};
				OFF_STAT: rdata <= {28'h0, refused, inSref, dllOn, lockWait};
				default: begin
					rdata <= '0;
					rresp <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule : sdmr_ctrl_end
`default_nettype wire

// ---- design/sdmr_dram_end.sv ----
// Overview of operation
// [RULE1] Mode set with select 001 loads register
// [RULE2] Controller holds strobes low for mode set
// [RULE3] Controller writes reserved bits 21, 17 zero
// [RULE4] Bit 12 disables drivers and termination
// [RULE5] Bit 11 enables extra strobe, x8 only
// [RULE6] Bits 10:8 pick nominal termination
// [RULE7] Bit 7 enters write-leveling mode
// [RULE8] Bits 4:3 pick added latency
// [RULE9] No latency minus one under gear-down
// [RULE10] Bits 2:1 pick driver impedance
// [RULE11] Bit 0 enables the delay-locked loop
// [RULE12] Controller keeps loop enabled normally
// [RULE13] Loop stops in self refresh, restarts after
// [RULE14] No reads until lock time passes
// [RULE15] Clock enable stays high during lock
// [RULE16] Writes need loop only for write termination
// [RULE17] Loop off: controller disables nominal termination
// [RULE18] Loop off: controller disables write termination
// [RULE19] Write termination applies even without nominal
// [RULE20] Park termination whenever termination input low
// [RULE21] Extra strobe removes data mask and inversion
// [RULE22] Reads and writes wait added latency
// [RULE23] Loop reset bit clears itself
// [RULE24] Fields hold until next targeted mode set
`timescale 1ns/1ps
`default_nettype none
module sdmr_dram_end #(
	parameter int DATA_WIDTH = 8,
	parameter int LOCK_CYCLES = sdmr_pkg::LOCK_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic rst,
	sdmr_link_if.dram link,
	input wire logic [4:0] casLatency,
	input wire logic [2:0] writeTermCode,
	input wire logic [2:0] parkTermCode,
	output logic [21:0] modeRegOne,
	output logic dllEnable,
	output logic dllRunning,
	output logic dllLocked,
	output logic loopResetBit,
	output logic selfRefresh,
	output logic outputsOff,
	output logic driverOn,
	output logic [1:0] driverCode,
	output logic [2:0] driverDivisor,
	output logic extraStrobeOn,
	output logic dataMaskAllowed,
	output logic dbiAllowed,
	output logic [2:0] nominalTermCode,
	output logic [2:0] nominalDivisor,
	output logic writeLevelMode,
	output logic [2:0] eqCode,
	output logic [1:0] addedLatencyCode,
	output logic [4:0] addedLatency,
	output logic execRead,
	output logic execWrite,
	output logic writeActive,
	output sdmr_pkg::sdmr_term_t termSel,
	output logic [2:0] termCode
);
	import sdmr_pkg::*;

	sdmr_cmd_t cmd;
	logic [21:0] mrWord;
	logic mrsOne;
	logic ckePrev;
	logic dllPrev;
	logic lockDone;
	logic lockRestart;
	logic srEnter;
	logic srExit;
	logic [AL_PIPE-1:0] rdPipe;
	logic [AL_PIPE-1:0] wrPipe;
	logic [2:0] wrCount;

	// Divisor of the calibration resistor; zero means no termination.
	function automatic logic [2:0] nomDiv(input logic [2:0] code);
		unique case (code)
			3'h0: nomDiv = 3'h0;
			3'h1: nomDiv = 3'h4;
			3'h2: nomDiv = 3'h2;
			3'h3: nomDiv = 3'h6;
			3'h4: nomDiv = 3'h1;
			3'h5: nomDiv = 3'h5;
			3'h6: nomDiv = 3'h3;
			3'h7: nomDiv = 3'h7;
		endcase
	endfunction : nomDiv

	// Code 10 is outside the standard set but still gives divisor six.
	function automatic logic [2:0] drvDiv(input logic [1:0] code);
		unique case (code)
			2'h0: drvDiv = 3'h7;
			2'h1: drvDiv = 3'h5;
			2'h2: drvDiv = 3'h6;
			2'h3: drvDiv = 3'h0;
		endcase
	endfunction : drvDiv

	// The reserved code falls back to no added latency.
	function automatic logic [4:0] alCycles(input logic [1:0] code,
		input logic [4:0] cl);
		if (code == AL_CL1) begin
			alCycles = cl - 5'h01;
		end else if (code == AL_CL2) begin
			alCycles = cl - 5'h02;
		end else begin
			alCycles = 5'h00;
		end
	endfunction : alCycles

	assign cmd = sdmr_decode(link.csN, {link.rasN, link.casN, link.weN});
	assign mrWord = {link.bank, link.addr};
	assign mrsOne = cmd == CMD_MRS &&
		mrWord[SEL_HI:SEL_LO] == SEL_MR1; // [RULE1]

	// Reserved bits are stored as zero whatever the controller sends.
	always_ff @(posedge clk) begin
		if (rst) begin
			modeRegOne <= MR1_RESET;
		end else if (mrsOne) begin // [RULE24]
			modeRegOne <= mrWord & ~((22'h1 << RSV_HI) |
				(22'h1 << RSV_LO)); // [RULE3]
		end
	end

	assign outputsOff = modeRegOne[B_QOFF]; // [RULE4]
	assign driverOn = !outputsOff; // [RULE4]
	assign driverCode = modeRegOne[DRV_HI:DRV_LO]; // [RULE10]
	assign driverDivisor = drvDiv(driverCode); // [RULE10]
	assign extraStrobeOn = modeRegOne[B_EXTRA_TERM_STROBE] && (DATA_WIDTH == 8); // [RULE5]
	assign dataMaskAllowed = !extraStrobeOn; // [RULE21]
	assign dbiAllowed = !extraStrobeOn; // [RULE21]
	assign nominalTermCode = modeRegOne[NOM_HI:NOM_LO]; // [RULE6]
	assign nominalDivisor = nomDiv(nominalTermCode); // [RULE6]
	assign writeLevelMode = modeRegOne[B_WLVL]; // [RULE7]
	assign eqCode = {modeRegOne[B_EQ2], modeRegOne[B_EQ1], modeRegOne[B_EQ0]};
	assign addedLatencyCode = modeRegOne[AL_HI:AL_LO]; // [RULE8]
	assign dllEnable = modeRegOne[B_DLL]; // [RULE11]

	always_ff @(posedge clk) begin
		if (rst) begin
			addedLatency <= 5'h00;
		end else begin
			addedLatency <= alCycles(addedLatencyCode, casLatency); // [RULE8]
		end
	end

	// Self refresh starts on a refresh with the clock enable falling.
	assign srEnter = cmd == CMD_REF && ckePrev && !link.cke;
	assign srExit = selfRefresh && link.cke;

	always_ff @(posedge clk) begin
		if (rst) begin
			ckePrev <= 1'b1;
			selfRefresh <= 1'b0;
		end else begin
			ckePrev <= link.cke;
			if (srEnter) begin
				selfRefresh <= 1'b1;
			end else if (srExit) begin
				selfRefresh <= 1'b0;
			end
		end
	end

	assign dllRunning = dllEnable && !selfRefresh; // [RULE13]

	// The reset bit lives for the one cycle in which the timer restarts.
	always_ff @(posedge clk) begin
		if (rst) begin
			loopResetBit <= 1'b0;
		end else begin
			loopResetBit <= cmd == CMD_MRS &&
				mrWord[SEL_HI:SEL_LO] == SEL_MR0 &&
				mrWord[B_LOOP_RST]; // [RULE23]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dllPrev <= 1'b0;
		end else begin
			dllPrev <= dllRunning;
		end
	end

	assign lockRestart = loopResetBit || (dllRunning && !dllPrev); // [RULE13]

	sdmr_lock_timer #(.CYCLES(LOCK_CYCLES)) lockTimer (
		.clk(clk),
		.rst(rst),
		.restart(lockRestart),
		.run(dllRunning && link.cke), // [RULE15]
		.done(lockDone)
	);

	assign dllLocked = lockDone && dllRunning; // [RULE14]

	// Commands are taken at once and released one cycle after the added latency.
	always_ff @(posedge clk) begin
		if (rst) begin
			rdPipe <= '0;
			wrPipe <= '0;
		end else begin
			rdPipe <= {rdPipe[AL_PIPE-2:0], cmd == CMD_RD}; // [RULE22]
			wrPipe <= {wrPipe[AL_PIPE-2:0], cmd == CMD_WR}; // [RULE22]
		end
	end

	assign execRead = rdPipe[addedLatency]; // [RULE22]
	assign execWrite = wrPipe[addedLatency]; // [RULE22]

	// Writes run with or without the loop.
	always_ff @(posedge clk) begin
		if (rst) begin
			wrCount <= 3'h0;
		end else if (execWrite) begin
			wrCount <= WR_TERM_WIN; // [RULE16]
		end else if (wrCount != 3'h0) begin
			wrCount <= wrCount - 3'h1;
		end
	end

	assign writeActive = wrCount != 3'h0;

	// Termination priority: disabled outputs, park, write, nominal.
	always_ff @(posedge clk) begin
		if (rst) begin
			termSel <= TERM_OFF;
			termCode <= TERM_NONE;
		end else if (outputsOff) begin
			termSel <= TERM_OFF; // [RULE4]
			termCode <= TERM_NONE;
		end else if (!link.termination_control) begin
			termSel <= (parkTermCode != TERM_NONE) ? TERM_PARK : TERM_OFF;
			termCode <= parkTermCode; // [RULE20]
		end else if (writeActive && writeTermCode != TERM_NONE &&
			dllRunning) begin // [RULE16]
			termSel <= TERM_WR; // [RULE19]
			termCode <= writeTermCode;
		end else if (nominalTermCode != TERM_NONE && dllRunning) begin
			termSel <= TERM_NOM; // [RULE6]
			termCode <= nominalTermCode;
		end else begin
			termSel <= TERM_OFF; // [RULE17]
			termCode <= TERM_NONE;
		end
	end
endmodule : sdmr_dram_end
`default_nettype wire

// ---- tb/sdmr_link_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdmr_link_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic csN,
	input wire logic rasN,
	input wire logic casN,
	input wire logic weN,
	input wire logic [3:0] bank,
	input wire logic [17:0] addr,
	input wire logic cke,
	input wire logic termination_control,
	input wire logic [4:0] casLatency,
	input wire logic [2:0] writeTermCode,
	input wire logic [2:0] parkTermCode,
	input wire logic [21:0] modeRegOne,
	input wire logic dllRunning,
	input wire logic loopResetBit,
	input wire logic selfRefresh,
	input wire logic outputsOff,
	input wire logic [1:0] driverCode,
	input wire logic [2:0] driverDivisor,
	input wire logic extraStrobeOn,
	input wire logic dataMaskAllowed,
	input wire logic [2:0] nominalTermCode,
	input wire logic [2:0] nominalDivisor,
	input wire logic [1:0] addedLatencyCode,
	input wire logic [4:0] addedLatency,
	input wire logic writeActive,
	input wire sdmr_pkg::sdmr_term_t termSel,
	input wire logic [2:0] termCode
);
	import sdmr_pkg::*;
	localparam logic [23:0] NOM_TAB = {3'h7, 3'h3, 3'h5, 3'h1,
		3'h6, 3'h2, 3'h4, 3'h0};
	localparam logic [11:0] DRV_TAB = {3'h0, 3'h6, 3'h5, 3'h7};
	logic isMrs;
	logic isOne;
	logic [4:0] expLat;
	assign isMrs = !csN && {rasN, casN, weN} == 3'h0;
	assign isOne = isMrs && bank[2:0] == SEL_MR1;
	always_ff @(posedge clk) begin
		expLat <= addedLatencyCode == AL_CL1 ? casLatency - 5'h1 :
			addedLatencyCode == AL_CL2 ? casLatency - 5'h2 : 5'h0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_mrs_load: assert property (
		isOne |=> modeRegOne == $past({bank, addr}))
		else $error("mode word not loaded");
	a_reserved_zero: assert property (
		isMrs |-> !bank[3] && !addr[17]) else $error("reserved bit sent");
	a_loopoff_noterm: assert property (
		isOne && !addr[0] |-> addr[10:8] == TERM_NONE)
		else $error("termination left on with loop off");
	a_loopoff_nowrterm: assert property (
		isMrs && bank[2:0] == SEL_MR2 && !modeRegOne[B_DLL] |->
		addr[11:9] == TERM_NONE)
		else $error("write termination left on with loop off");
	a_field_hold: assert property (
		!isOne |=> $stable(modeRegOne)) else $error("mode word drifted");
	a_outputs_off: assert property (
		outputsOff |=> termSel == TERM_OFF) else $error("outputs not off");
	a_strobe_mask: assert property (
		extraStrobeOn == modeRegOne[B_EXTRA_TERM_STROBE] && dataMaskAllowed == !extraStrobeOn)
		else $error("extra strobe decode wrong");
	a_nom_table: assert property (
		nominalTermCode == modeRegOne[NOM_HI:NOM_LO] &&
		nominalDivisor == NOM_TAB[nominalTermCode * 3 +: 3])
		else $error("nominal termination decode wrong");
	a_drv_table: assert property (
		driverCode == modeRegOne[DRV_HI:DRV_LO] &&
		driverDivisor == DRV_TAB[driverCode * 3 +: 3])
		else $error("driver impedance decode wrong");
	a_added_lat: assert property (
		!rst |=> addedLatency == expLat) else $error("added latency wrong");
	a_sref_entry: assert property (
		!csN && {rasN, casN, weN} == 3'h1 && !cke |=> selfRefresh && !dllRunning)
		else $error("loop still running in self refresh");
	a_sref_exit: assert property (
		selfRefresh && cke |=> !selfRefresh && dllRunning == modeRegOne[B_DLL])
		else $error("loop not back after self refresh");
	a_park_term: assert property (
		!termination_control && !outputsOff && parkTermCode != 3'h0 |=>
		termSel == TERM_PARK && termCode == $past(parkTermCode))
		else $error("park termination not applied");
	a_wr_term: assert property (
		writeActive && termination_control && !outputsOff && writeTermCode != 3'h0 &&
		dllRunning |=> termSel == TERM_WR) else $error("write termination missing");
	a_loop_clear: assert property (
		loopResetBit |=> !loopResetBit) else $error("loop reset bit stuck");
	c_mrs_one: cover property (isOne);
	c_sref: cover property (selfRefresh ##1 !selfRefresh);
	c_wr_term: cover property (termSel == TERM_WR);
endmodule : sdmr_link_sva
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sdmr_pkg::*;
	localparam int LOCK = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic bready = 1'b1, rready = 1'b1;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [4:0] casLatency = 5'h10;
	logic [2:0] writeTermCode = 3'h1, parkTermCode = 3'h2;
	logic [21:0] modeRegOne;
	logic dllRunning, dllLocked, loopResetBit, selfRefresh, outputsOff;
	logic [1:0] driverCode, addedLatencyCode;
	logic [2:0] driverDivisor, nominalTermCode, nominalDivisor, termCode;
	logic extraStrobeOn, dataMaskAllowed, writeActive;
	logic [4:0] addedLatency;
	sdmr_term_t termSel;
	logic [33:0] expR[$];
	logic [1:0] expB[$];
	int n_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int seed = 80;

	sdmr_link_if sdmr_link_if_inst ();
	sdmr_ctrl_end #(.LOCK_CYCLES(LOCK)) sdmr_ctrl_end_inst (.clk, .rst,
		.link(sdmr_link_if_inst), .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready);
	sdmr_dram_end #(.DATA_WIDTH(8), .LOCK_CYCLES(LOCK)) sdmr_dram_end_inst (
		.clk, .rst, .link(sdmr_link_if_inst), .casLatency, .writeTermCode,
		.parkTermCode, .modeRegOne, .dllEnable(), .dllRunning, .dllLocked,
		.loopResetBit, .selfRefresh, .outputsOff, .driverOn(), .driverCode,
		.driverDivisor, .extraStrobeOn, .dataMaskAllowed, .dbiAllowed(),
		.nominalTermCode, .nominalDivisor, .writeLevelMode(), .eqCode(),
		.addedLatencyCode, .addedLatency, .execRead(), .execWrite(),
		.writeActive, .termSel, .termCode);
	sdmr_link_sva sdmr_link_sva_inst (.clk, .rst,
		.csN(sdmr_link_if_inst.csN), .rasN(sdmr_link_if_inst.rasN),
		.casN(sdmr_link_if_inst.casN), .weN(sdmr_link_if_inst.weN),
		.bank(sdmr_link_if_inst.bank), .addr(sdmr_link_if_inst.addr),
		.cke(sdmr_link_if_inst.cke), .termination_control(sdmr_link_if_inst.termination_control), .casLatency,
		.writeTermCode, .parkTermCode, .modeRegOne, .dllRunning, .loopResetBit,
		.selfRefresh, .outputsOff, .driverCode, .driverDivisor, .extraStrobeOn,
		.dataMaskAllowed, .nominalTermCode, .nominalDivisor, .addedLatencyCode,
		.addedLatency, .writeActive, .termSel, .termCode);

	always #2.5 clk = ~clk;

	task automatic check(input string what, input logic [33:0] exp,
		input logic [33:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end

	// Responses are scored here in the order the requests were issued.
	always @(posedge clk) begin
		if (rvalid === 1'b1 && rready === 1'b1) begin
			check("read response", expR.pop_front(), {rresp, rdata});
		end
		if (bvalid === 1'b1 && bready === 1'b1) begin
			check("write response", 34'(expB.pop_front()), 34'(bresp));
		end
	end

	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] r = RESP_OKAY);
		logic awPend;
		logic wPend;
		awPend = 1'b1;
		wPend = 1'b1;
		expB.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (awPend || wPend) begin
			@(posedge clk);
			if (awPend && awready === 1'b1) begin
				awPend = 1'b0;
				awvalid <= 1'b0;
			end
			if (wPend && wready === 1'b1) begin
				wPend = 1'b0;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clk);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [33:0] e);
		expR.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
	endtask : rd

	task automatic mode_set_command(input logic [21:0] w);
		wr(OFF_WORD, 32'(w));
		wr(OFF_CMD, 32'h1);
		repeat (2) @(posedge clk);
	endtask : mode_set_command

	initial begin
		logic [21:0] w;
		logic [21:0] cur;
		logic seen;
		@(posedge clk);
		casLatency <= 5'(12 + ($random(seed) & 7));
		writeTermCode <= 3'($random(seed)) | 3'h1;
		parkTermCode <= 3'($random(seed)) | 3'h1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		check("reset word", 34'(MR1_RESET), 34'(modeRegOne));
		rd(OFF_STAT, {RESP_OKAY, 32'h3});
		repeat (LOCK + 4) @(posedge clk);
		check("locked", 34'h1, 34'(dllLocked));
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			w = 22'($random(seed));
			w[SEL_HI:SEL_LO] = SEL_MR1;
			w[NOM_HI:NOM_LO] = 3'(i);
			w[AL_HI:AL_LO] = 2'(i);
			w[DRV_HI:DRV_LO] = 2'(i);
			cur = w;
			cur[RSV_HI] = 1'b0;
			cur[RSV_LO] = 1'b0;
			if (!w[B_DLL]) begin
				cur[NOM_HI:NOM_LO] = TERM_NONE;
			end
			mode_set_command(w);
			check("mode word", 34'(cur), 34'(modeRegOne));
		end
		mode_set_command(22'h08ffff);
		check("other select", 34'(cur), 34'(modeRegOne));
		mode_set_command(22'h000100);
		cur = 22'h040911;
		mode_set_command(cur);
		repeat (LOCK + 4) @(posedge clk);
		$display("test mode load done");
		wr(OFF_CTRL, 32'h2);
		mode_set_command(22'h040009);
		check("gear refused", 34'(cur), 34'(modeRegOne));
		rd(OFF_STAT, {RESP_OKAY, 32'ha});
		wr(OFF_STAT, 32'h8);
		wr(OFF_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		check("nominal term", 34'(TERM_NOM), 34'(termSel));
		mode_set_command(22'h040801);
		wr(OFF_CMD, 32'h4);
		seen = 1'b0;
		repeat (8) begin
			@(posedge clk);
			seen = seen | (termSel === TERM_WR);
		end
		check("write term", 34'h1, 34'(seen));
		wr(OFF_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		check("park", 34'({TERM_PARK, parkTermCode}),
			34'({termSel, termCode}));
		mode_set_command(22'h041001);
		check("off", 34'(TERM_OFF), 34'(termSel));
		$display("test termination done");
		mode_set_command(22'h040001);
		wr(OFF_CMD, 32'h6);
		repeat (2) @(posedge clk);
		check("sref", 34'h2, 34'({selfRefresh, dllRunning}));
		wr(OFF_CMD, 32'h3);
		rd(OFF_STAT, {RESP_OKAY, 32'he});
		wr(OFF_CMD, 32'h7);
		repeat (2) @(posedge clk);
		check("exit", 34'h1, 34'({selfRefresh, dllRunning}));
		check("relock", 34'h0, 34'(dllLocked));
		repeat (LOCK + 4) @(posedge clk);
		check("locked again", 34'h1, 34'(dllLocked));
		$display("test self refresh done");
		wr(4'h2, 32'h0, RESP_SLVERR);
		rd(4'h3, {RESP_SLVERR, 32'h0});
		repeat (2) @(posedge clk);
		$display("test bad address done");
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
